//--- core/vtm_cmd_check.sv
// Legality check of a requested command against training state
`timescale 1ns/1ps
`default_nettype none
module vtm_cmd_check (
  input wire vtm_pkg::vtm_req_t i_req,
  input wire logic i_training,
  input wire logic i_pda,
  input wire logic i_banks_idle,
  output logic o_legal
);
  import vtm_pkg::*;

  always_comb begin
    o_legal = 1'b0;
    unique case (i_req.op)
      VTM_OP_ENTER: o_legal = !i_training;
      VTM_OP_SET: o_legal = i_training;
      VTM_OP_EXIT: o_legal = i_training && i_banks_idle;
      VTM_OP_ACT, VTM_OP_WR, VTM_OP_RD, VTM_OP_PRE: o_legal = !(i_training && i_pda);
      default: o_legal = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- core/vtm_ctrl.sv
// Host controller sequencing reference training over the memory command pins
//
// Notes on behaviour
// - enter by writing enable bit 1; exit by writing it 0.
// - range bit selects one of two ranges, sent with entry.
// - entry value is don't-care; following setting command carries the value.
// - wait 150 ns after entry before any training-legal command.
// - only array, deselect and training register commands during training.
// - with per-device addressing, only setting and exit commands.
// - exit only while all banks are closed.
// - only deselects for 150 ns after exit.
// - allow settling time after last value change before exit.
// - range 1 uses mode and range bits 10 throughout.
// - range 2 uses mode and range bits 11 throughout.
// - clock enable held high throughout calibration.
// - termination control held low during calibration.
// - other devices on data bus stay quiet during calibration.
`timescale 1ns/1ps
`default_nettype none
module vtm_ctrl #(
  parameter int ENTRY_CYC = vtm_pkg::VTM_ENTRY_CYC,
  parameter int EXIT_CYC = vtm_pkg::VTM_EXIT_CYC,
  parameter int SETTLE_CYC = vtm_pkg::VTM_SETTLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output vtm_pkg::vtm_pin_cmd_t o_pin_cmd,
  output logic o_cke,
  output logic o_odt,
  output logic o_dq_lb0,
  output logic o_dq_lb0_oe,
  output logic o_zq_quiet
);
  import vtm_pkg::*;

  // ==================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ENTRY_WAIT = 3'h1,
    ST_TRAIN = 3'h2,
    ST_SETTLE = 3'h3,
    ST_EXIT_WAIT = 3'h4
  } vtm_state_t;

  vtm_state_t state_r;
  vtm_state_t state_nxt;
  logic pda_r;
  logic pda_nxt;
  logic zq_r;
  logic zq_nxt;
  logic range_r;
  logic range_nxt;
  logic [5:0] last_val_r;
  logic [5:0] last_val_nxt;
  logic [3:0] open_banks_r;
  logic [3:0] open_banks_nxt;
  logic refused_r;
  logic refused_nxt;
  logic exit_pend_r;
  logic exit_pend_nxt;
  vtm_pin_cmd_t pin_r;
  vtm_pin_cmd_t pin_nxt;
  logic lb0_oe_r;
  logic lb0_oe_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  vtm_req_t req;
  logic legal;
  logic training;
  logic busy;
  logic load;
  logic [VTM_CNT_W-1:0] load_val;
  logic cmd_wr;

  // ==================================================================
  // Request decode
  assign cmd_wr = i_wr && (i_addr == VTM_REG_CMD);
  assign req.op = i_wdata[10:8];
  assign req.range = i_wdata[6];
  assign req.value = i_wdata[5:0];
  assign req.auto_pre = i_wdata[11];
  assign training = (state_r != ST_IDLE) && (state_r != ST_EXIT_WAIT);

  vtm_cmd_check u_check (
    .i_req(req),
    .i_training(training),
    .i_pda(pda_r),
    .i_banks_idle(open_banks_r == 4'h0),
    .o_legal(legal)
  );

  vtm_delay #(
    .W(VTM_CNT_W)
  ) u_delay (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_load(load),
    .i_count(load_val),
    .o_busy(busy)
  );

  function automatic logic [7:0] tc_word(input logic en, input logic rng,
                                         input logic [5:0] val);
    tc_word = {en, rng, val};
  endfunction

  // ==================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    pda_nxt = pda_r;
    zq_nxt = zq_r;
    range_nxt = range_r;
    last_val_nxt = last_val_r;
    open_banks_nxt = open_banks_r;
    refused_nxt = refused_r;
    exit_pend_nxt = exit_pend_r;
    pin_nxt = '{cmd: VTM_C_DES, mr_sel: 3'h0, addr: 8'h00};
    lb0_oe_nxt = 1'b0;
    load = 1'b0;
    load_val = '0;
    rdata_nxt = 32'h0;

    if (i_rd) begin
      unique case (i_addr)
        VTM_REG_CTRL: rdata_nxt = {30'h0, zq_r, pda_r};
        VTM_REG_STATUS: rdata_nxt = {24'h0, open_banks_r, refused_r, busy, training,
                                     exit_pend_r};
        VTM_REG_LAST: rdata_nxt = {25'h0, range_r, last_val_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
    if (i_wr && (i_addr == VTM_REG_CTRL)) begin
      pda_nxt = i_wdata[VTM_CTRL_PDA_BIT];
      zq_nxt = i_wdata[VTM_CTRL_ZQ_BIT];
    end
    if (i_wr && (i_addr == VTM_REG_STATUS) && i_wdata[3]) begin
      refused_nxt = 1'b0;
    end

    unique case (state_r)
      ST_ENTRY_WAIT: begin
        // hold off until entry delay done
        if (!busy) begin
          state_nxt = ST_TRAIN;
        end
      end
      ST_SETTLE: begin
        if (!busy && exit_pend_r) begin
          // range and value bits sent as zero
          pin_nxt = '{cmd: VTM_C_MRS, mr_sel: VTM_TC_REG_SEL, addr: VTM_TC_EXIT_WORD};
          lb0_oe_nxt = pda_r;
          exit_pend_nxt = 1'b0;
          load = 1'b1;
          load_val = VTM_CNT_W'(EXIT_CYC);
          state_nxt = ST_EXIT_WAIT;
        end else if (!busy) begin
          state_nxt = ST_TRAIN;
        end
      end
      ST_EXIT_WAIT: begin
        // deselects only until exit delay done
        if (!busy) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
      end
    endcase

    // Requests only in idle or training; else refused
    if (cmd_wr && (busy || zq_r || !((state_r == ST_IDLE) || (state_r == ST_TRAIN))
        || !legal)) begin
      refused_nxt = 1'b1;
    end else if (cmd_wr) begin
      unique case (req.op)
        VTM_OP_ENTER: begin
          // range 1 sends mode bits 10
          // range 2 sends mode bits 11
          range_nxt = req.range;
          pin_nxt = '{cmd: VTM_C_MRS, mr_sel: VTM_TC_REG_SEL,
                      addr: tc_word(1'b1, req.range, 6'h00)};
          lb0_oe_nxt = pda_r;
          load = 1'b1;
          load_val = VTM_CNT_W'(ENTRY_CYC);
          state_nxt = ST_ENTRY_WAIT;
        end
        VTM_OP_SET: begin
          last_val_nxt = req.value;
          pin_nxt = '{cmd: VTM_C_MRS, mr_sel: VTM_TC_REG_SEL,
                      addr: tc_word(1'b1, range_r, req.value)};
          lb0_oe_nxt = pda_r;
          load = 1'b1;
          load_val = VTM_CNT_W'(SETTLE_CYC);
          state_nxt = ST_SETTLE;
        end
        VTM_OP_EXIT: begin
          exit_pend_nxt = 1'b1;
          state_nxt = ST_SETTLE;
        end
        VTM_OP_ACT: begin
          pin_nxt = '{cmd: VTM_C_ACT, mr_sel: 3'h0, addr: {6'h00, req.value[1:0]}};
          open_banks_nxt = open_banks_r | (4'h1 << req.value[1:0]);
        end
        VTM_OP_WR, VTM_OP_RD: begin
          pin_nxt.cmd = (req.op == VTM_OP_WR) ? (req.auto_pre ? VTM_C_WRA : VTM_C_WR)
                                               : (req.auto_pre ? VTM_C_RDA : VTM_C_RD);
          pin_nxt.addr = {6'h00, req.value[1:0]};
          if (req.auto_pre) begin
            open_banks_nxt = open_banks_r & ~(4'h1 << req.value[1:0]);
          end
        end
        VTM_OP_PRE: begin
          pin_nxt = '{cmd: VTM_C_PRE, mr_sel: 3'h0, addr: {6'h00, req.value[1:0]}};
          open_banks_nxt = open_banks_r & ~(4'h1 << req.value[1:0]);
        end
        default: begin
        end
      endcase
    end
  end

  // ==================================================================
  // Registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_r <= ST_IDLE;
      pda_r <= 1'b0;
      zq_r <= 1'b0;
      range_r <= 1'b0;
      last_val_r <= 6'h00;
      open_banks_r <= 4'h0;
      refused_r <= 1'b0;
      exit_pend_r <= 1'b0;
      pin_r <= '{cmd: VTM_C_DES, mr_sel: 3'h0, addr: 8'h00};
      lb0_oe_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      pda_r <= pda_nxt;
      zq_r <= zq_nxt;
      range_r <= range_nxt;
      last_val_r <= last_val_nxt;
      open_banks_r <= open_banks_nxt;
      refused_r <= refused_nxt;
      exit_pend_r <= exit_pend_nxt;
      pin_r <= pin_nxt;
      lb0_oe_r <= lb0_oe_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_pin_cmd = pin_r;
  assign o_cke = 1'b1;
  assign o_odt = 1'b0;
  assign o_dq_lb0 = 1'b0;
  assign o_dq_lb0_oe = lb0_oe_r;
  assign o_zq_quiet = zq_r;
endmodule
`default_nettype wire

//--- core/vtm_delay.sv
// Down counter for quiet intervals
`timescale 1ns/1ps
`default_nettype none
module vtm_delay #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_busy
);
  import vtm_pkg::*;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_busy = (cnt_r != '0);
endmodule
`default_nettype wire

//--- core/vtm_pkg.sv
// Package: constants and carriers for the DQ reference training controller
package vtm_pkg;
  // Training control register bit positions (device side)
  localparam int VTM_TC_EN_BIT = 7;
  localparam int VTM_TC_RANGE_BIT = 6;
  localparam int VTM_TC_VAL_W = 6;
  localparam logic [7:0] VTM_TC_EXIT_WORD = 8'h00;
  localparam logic [1:0] VTM_TC_MODE_BIT_SET_R1 = 2'h2;
  localparam logic [1:0] VTM_TC_MODE_BIT_SET_R2 = 2'h3;
  localparam logic [2:0] VTM_TC_REG_SEL = 3'h6;

  // Timing
  localparam int VTM_CLK_PERIOD_PS = 40000;
  localparam int VTM_ENTRY_DELAY_NS = 150;
  localparam int VTM_EXIT_DELAY_NS = 150;
  localparam int VTM_SETTLE_NS = 150;
  localparam int VTM_ENTRY_CYC = (VTM_ENTRY_DELAY_NS * 1000 + VTM_CLK_PERIOD_PS - 1)
    / VTM_CLK_PERIOD_PS;
  localparam int VTM_EXIT_CYC = (VTM_EXIT_DELAY_NS * 1000 + VTM_CLK_PERIOD_PS - 1)
    / VTM_CLK_PERIOD_PS;
  localparam int VTM_SETTLE_CYC = (VTM_SETTLE_NS * 1000 + VTM_CLK_PERIOD_PS - 1)
    / VTM_CLK_PERIOD_PS;
  localparam int VTM_CNT_W = 8;

  // Software register offsets (controller's own)
  localparam logic [3:0] VTM_REG_CTRL = 4'h0;
  localparam logic [3:0] VTM_REG_CMD = 4'h1;
  localparam logic [3:0] VTM_REG_STATUS = 4'h2;
  localparam logic [3:0] VTM_REG_LAST = 4'h3;
  // CTRL fields
  localparam int VTM_CTRL_PDA_BIT = 0;
  localparam int VTM_CTRL_ZQ_BIT = 1;
  // CMD opcodes (write data [10:8]), value in [5:0], range in [6]
  localparam logic [2:0] VTM_OP_ENTER = 3'h1;
  localparam logic [2:0] VTM_OP_SET = 3'h2;
  localparam logic [2:0] VTM_OP_EXIT = 3'h3;
  localparam logic [2:0] VTM_OP_ACT = 3'h4;
  localparam logic [2:0] VTM_OP_WR = 3'h5;
  localparam logic [2:0] VTM_OP_RD = 3'h6;
  localparam logic [2:0] VTM_OP_PRE = 3'h7;

  // Memory command codes on the command pins
  typedef enum logic [3:0] {
    VTM_C_DES = 4'h0,
    VTM_C_MRS = 4'h1,
    VTM_C_ACT = 4'h2,
    VTM_C_WR = 4'h3,
    VTM_C_WRA = 4'h4,
    VTM_C_RD = 4'h5,
    VTM_C_RDA = 4'h6,
    VTM_C_PRE = 4'h7
  } vtm_cmd_t;

  typedef struct packed {
    vtm_cmd_t cmd;
    logic [2:0] mr_sel;
    logic [7:0] addr;
  } vtm_pin_cmd_t;

  typedef struct packed {
    logic [2:0] op;
    logic range;
    logic [5:0] value;
    logic auto_pre;
  } vtm_req_t;
endpackage

//--- testbench/tb.sv
// Self-checking bench for the training controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vtm_pkg::*;
  logic i_clk, i_srst, i_wr, i_rd, rd_d, oe, lb0, zq, per_device_addressing, trn;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, rdata;
  logic [6:0] dref, last;
  logic [5:0] v;
  vtm_pin_cmd_t pc, e;
  vtm_pin_cmd_t exp_q[$];
  logic [31:0] rd_q[$];
  int failures, check_count, cyc, seed;
  vtm_ctrl dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .o_pin_cmd(pc), .o_cke(), .o_odt(),
    .o_dq_lb0(lb0), .o_dq_lb0_oe(oe), .o_zq_quiet(zq));
  // Undriven lane bit is pulled high, so the device would skip the write
  vtm_dev_model mem (.i_clk(i_clk), .i_srst(i_srst), .i_cmd(pc), .i_pda(per_device_addressing),
    .i_lb0(oe ? lb0 : 1'b1), .o_trn(trn), .o_ref(dref));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // ====
  // Tasks
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic op(input logic [2:0] o, input logic r, input logic [5:0] val);
    wr(VTM_REG_CMD, {21'h0, o, 1'b0, r, val});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  function automatic vtm_pin_cmd_t mk(input vtm_cmd_t c, input logic [7:0] a);
    return '{c, VTM_TC_REG_SEL, a};
  endfunction
  task automatic end_of_test();
    $display("failures=%0d check_count=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ====
  // Watchers
  always @(posedge i_clk) begin
    rd_d <= i_rd;
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_of_test();
    end
  end
  always @(negedge i_clk) begin
    if (rd_d === 1'b1) begin
      cmp(rdata, rd_q.pop_front());
    end
    if (!i_srst && pc.cmd !== VTM_C_DES) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
      cmp(32'(pc.cmd), 32'(e.cmd));
      if (e.cmd == VTM_C_MRS) cmp(32'(pc), 32'(e));
    end
  end
  // ====
  // Scenarios
  initial begin
    seed = 90080;
    per_device_addressing = 1'b0;
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    idle(4);
    i_srst <= 1'b0;
    rd(VTM_REG_STATUS, 32'h0);
    rd(4'hf, 32'h0);
    for (int r = 0; r < 2; r++) begin
      exp_q.push_back(mk(VTM_C_MRS, {1'b1, r[0], 6'h00}));
      op(VTM_OP_ENTER, r[0], 6'($random(seed)));
      op(VTM_OP_SET, r[0], 6'h3f);
      idle(6);
      rd(VTM_REG_STATUS, 32'h0a);
      wr(VTM_REG_STATUS, 32'h08);
      repeat (2) begin
        v = 6'($random(seed));
        last = {r[0], v};
        exp_q.push_back(mk(VTM_C_MRS, {1'b1, last}));
        op(VTM_OP_SET, r[0], v);
        // Settling counts as busy and still training
        rd(VTM_REG_STATUS, 32'h06);
        idle(6);
      end
      exp_q.push_back(mk(VTM_C_ACT, 8'h00));
      op(VTM_OP_ACT, r[0], v);
      exp_q.push_back(mk(r[0] ? VTM_C_RD : VTM_C_WR, 8'h00));
      op(r[0] ? VTM_OP_RD : VTM_OP_WR, r[0], v);
      op(VTM_OP_EXIT, r[0], v);
      exp_q.push_back(mk(VTM_C_PRE, 8'h00));
      op(VTM_OP_PRE, r[0], v);
      // Auto-precharge must close the bank, else the exit below is refused
      exp_q.push_back(mk(VTM_C_ACT, 8'h00));
      op(VTM_OP_ACT, r[0], v);
      exp_q.push_back(mk(r[0] ? VTM_C_WRA : VTM_C_RDA, 8'h00));
      wr(VTM_REG_CMD, {20'h0, 1'b1, r[0] ? VTM_OP_WR : VTM_OP_RD, 2'b00, v});
      rd(VTM_REG_LAST, {25'h0, last});
      wr(VTM_REG_STATUS, 32'h08);
      exp_q.push_back(mk(VTM_C_MRS, VTM_TC_EXIT_WORD));
      op(VTM_OP_EXIT, r[0], v);
      idle(14);
      cmp({25'h0, dref}, {25'h0, last});
      rd(VTM_REG_STATUS, 32'h0);
    end
    per_device_addressing <= 1'b1;
    wr(VTM_REG_CTRL, 32'h1);
    rd(VTM_REG_CTRL, 32'h1);
    exp_q.push_back(mk(VTM_C_MRS, 8'hc0));
    op(VTM_OP_ENTER, 1'b1, 6'h00);
    idle(6);
    op(VTM_OP_ACT, 1'b1, 6'h00);
    v = 6'($random(seed));
    exp_q.push_back(mk(VTM_C_MRS, {2'b11, v}));
    op(VTM_OP_SET, 1'b1, v);
    // Exit is accepted once the new value has settled; the ACT above was refused
    idle(6);
    exp_q.push_back(mk(VTM_C_MRS, VTM_TC_EXIT_WORD));
    op(VTM_OP_EXIT, 1'b1, v);
    idle(14);
    cmp({25'h0, dref}, {25'h0, 1'b1, v});
    rd(VTM_REG_STATUS, 32'h08);
    wr(VTM_REG_STATUS, 32'h08);
    wr(VTM_REG_CTRL, 32'h2);
    per_device_addressing <= 1'b0;
    idle(2);
    cmp({31'h0, zq}, 32'h1);
    op(VTM_OP_ENTER, 1'b0, 6'h00);
    rd(VTM_REG_STATUS, 32'h08);
    wr(VTM_REG_CTRL, 32'h0);
    idle(4);
    cmp(32'(exp_q.size()), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- testbench/vtm_chk.sv
// Port checker for the reference training controller
`timescale 1ns/1ps
`default_nettype none
module vtm_chk
  import vtm_pkg::*;
#(
  parameter int ENTRY_CYC = 4,
  parameter int EXIT_CYC = 4,
  parameter int SETTLE_CYC = 4
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire vtm_pin_cmd_t o_pin_cmd,
  input wire logic o_cke,
  input wire logic o_odt,
  input wire logic o_dq_lb0,
  input wire logic o_dq_lb0_oe,
  input wire logic o_zq_quiet
);
  logic trn_r, trn_nxt, rng_r, rng_nxt, pda_r, pda_nxt, mrs, ent, stp, ext;
  // ====
  // Device mode as seen from the pins
  assign mrs = o_pin_cmd.cmd == VTM_C_MRS;
  assign ent = mrs && o_pin_cmd.addr[7] && !trn_r;
  assign stp = mrs && o_pin_cmd.addr[7] && trn_r;
  assign ext = mrs && !o_pin_cmd.addr[7];
  always_comb begin
    trn_nxt = i_srst ? 1'b0 : (mrs ? o_pin_cmd.addr[7] : trn_r);
    rng_nxt = ent ? o_pin_cmd.addr[6] : rng_r;
    pda_nxt = i_srst ? 1'b0 : ((i_wr && i_addr == VTM_REG_CTRL) ? i_wdata[0] : pda_r);
  end
  always_ff @(posedge i_clk) begin
    trn_r <= trn_nxt;
    rng_r <= rng_nxt;
    pda_r <= pda_nxt;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // ====
  // Properties
  chk_cke_high: assert property (o_cke) else $error("cke low");
  chk_odt_low: assert property (o_zq_quiet |-> !o_odt) else $error("odt high");
  chk_zq_bus: assert property (o_zq_quiet |-> o_pin_cmd.cmd == VTM_C_DES)
    else $error("command in calibration");
  chk_zq_follow: assert property (i_wr && i_addr == VTM_REG_CTRL
    |=> o_zq_quiet == $past(i_wdata[1])) else $error("quiet flag wrong");
  chk_entry_gap: assert property (ent |=> o_pin_cmd.cmd == VTM_C_DES [*3])
    else $error("command too soon after entry");
  chk_exit_gap: assert property (ext |=> o_pin_cmd.cmd == VTM_C_DES [*3])
    else $error("command too soon after exit");
  chk_settle_gap: assert property (stp |=> !ext [*3]) else $error("exit before settle");
  chk_range_keep: assert property (stp |-> o_pin_cmd.addr[6] == rng_r)
    else $error("range changed");
  chk_exit_word: assert property (ext |-> o_pin_cmd.addr == VTM_TC_EXIT_WORD)
    else $error("bad exit word");
  chk_mr_select: assert property (mrs |-> o_pin_cmd.mr_sel == VTM_TC_REG_SEL)
    else $error("bad register select");
  chk_pda_only: assert property (pda_r && trn_r
    |-> o_pin_cmd.cmd inside {VTM_C_DES, VTM_C_MRS}) else $error("array cmd in pda");
  chk_pda_qual: assert property (pda_r && mrs |-> o_dq_lb0_oe && !o_dq_lb0)
    else $error("lane bit not driven low");
  cover property (ent);
  cover property (ext);
  cover property (pda_r && stp);
endmodule
bind vtm_ctrl vtm_chk #(
  .ENTRY_CYC(ENTRY_CYC), .EXIT_CYC(EXIT_CYC), .SETTLE_CYC(SETTLE_CYC)
) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_pin_cmd(o_pin_cmd), .o_cke(o_cke), .o_odt(o_odt),
  .o_dq_lb0(o_dq_lb0), .o_dq_lb0_oe(o_dq_lb0_oe), .o_zq_quiet(o_zq_quiet)
);
`default_nettype wire

//--- testbench/vtm_dev_model.sv
// Memory device model: training control register and internal reference
`timescale 1ns/1ps
`default_nettype none
module vtm_dev_model
  import vtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire vtm_pin_cmd_t i_cmd,
  input wire logic i_pda,
  input wire logic i_lb0,
  output logic o_trn,
  output logic [6:0] o_ref
);
  logic [6:0] tc_r;
  logic go;
  assign go = i_cmd.cmd == VTM_C_MRS && i_cmd.mr_sel == VTM_TC_REG_SEL && !(i_pda && i_lb0);
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_trn <= 1'b0;
      o_ref <= 7'h00;
      tc_r <= 7'h00;
    end else if (go && i_cmd.addr[7] && !o_trn) begin
      o_trn <= 1'b1;
      tc_r[6] <= i_cmd.addr[6];
    end else if (go && i_cmd.addr[7]) begin
      tc_r <= i_cmd.addr[6:0];
    end else if (go) begin
      o_trn <= 1'b0;
      o_ref <= tc_r;
    end
  end
endmodule
`default_nettype wire
